/* dmct_pkg.sv */
// Notes on behaviour
// - each count is sixteen bits, two bytes
// - four modes per timer, settings independent
// - mode 0 counts thirteen bits, high:low[4:0]
// - thirteen-bit wrap sets flag, may interrupt
// - counter select counts falling pin edges
// - else system clock or prescaled clock
// - count only when run and gate allow, except in split: high byte ignores gate, timer one ignores both
// - gate activity follows its polarity bit
// - run bit never clears or loads count
// - mode 1 is mode 0 with sixteen bits
// - mode 2 reloads low from high on wrap
// - split low byte uses timer zero controls
// - split high byte timer, run by timer one
// - split high overflow sets timer one flag
// - timer one then internal clock, no flag
// - timer one overflow pulse still delivered
// - timer one stops in its mode 3
// - interrupt needs flag and enable bit
// - prescaler divides 12, 4, 48 or ext/8
// - pin events up to quarter clock rate
// - flags writable, cleared on vector acknowledge
package dmct_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_TL0 = 4'h2;
  localparam logic [3:0] ADDR_TH0 = 4'h3;
  localparam logic [3:0] ADDR_TL1 = 4'h4;
  localparam logic [3:0] ADDR_TH1 = 4'h5;
  localparam logic [3:0] ADDR_CLK = 4'h6;
  localparam logic [3:0] ADDR_GPOL = 4'h7;
  localparam logic [3:0] ADDR_IEN = 4'h8;
  localparam int TF1_BIT = 7;
  localparam int TR1_BIT = 6;
  localparam int TF0_BIT = 5;
  localparam int TR0_BIT = 4;
  localparam int M0_LSB = 0;
  localparam int CT0_BIT = 2;
  localparam int GATE_ENABLE_BIT_BIT = 3;
  localparam int M1_LSB = 4;
  localparam int CT1_BIT = 6;
  localparam int GATE1_BIT = 7;
  localparam int T1M_BIT = 3;
  localparam int T0M_BIT = 2;
  localparam int SCA_LSB = 0;
  localparam int POL0_BIT = 0;
  localparam int POL1_BIT = 1;
  localparam int IEN0_BIT = 0;
  localparam int IEN1_BIT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [12:0] MAX13 = 13'h1fff;
  localparam logic [15:0] MAX16 = 16'hffff;
  localparam logic [5:0] DIV_SYS12 = 6'h0c;
  localparam logic [5:0] DIV_SYS4 = 6'h04;
  localparam logic [5:0] DIV_SYS48 = 6'h30;
  localparam logic [5:0] DIV_EXT8 = 6'h08;
  localparam logic [1:0] SCA_EXT = 2'h3;
  localparam int PIN_CNT = 5;
  localparam int PIN_CNT0 = 0;
  localparam int PIN_CNT1 = 1;
  localparam int PIN_GATE_ENABLE_BIT = 2;
  localparam int PIN_GATE1 = 3;
  localparam int PIN_EXTCLK = 4;
  typedef enum logic [1:0] {DMCT_MODE13, DMCT_MODE16, DMCT_RELOAD8, DMCT_SPLIT8} dmct_mode_t;
  function automatic logic dmct_hit(input logic en, input logic [3:0] addr, input logic [3:0] off);
    dmct_hit = en && (addr == off);
  endfunction
endpackage

/* dmct_pin_if.sv */
`timescale 1ns/100ps
interface dmct_pin_if;
  import dmct_pkg::*;
  logic [PIN_CNT-1:0] level;
  logic [PIN_CNT-1:0] fall;
  logic [PIN_CNT-1:0] rise;
  modport src (output level, output fall, output rise);
  modport dst (input level, input fall, input rise);
endinterface

/* dmct_pin_sync.sv */
`timescale 1ns/100ps
module dmct_pin_sync
  import dmct_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [PIN_CNT-1:0] pins,
  dmct_pin_if.src sync
);
  logic [PIN_CNT-1:0] s1_r;
  logic [PIN_CNT-1:0] s2_r;
  logic [PIN_CNT-1:0] s3_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // edges come from the second and third stages only
  assign sync.level = s2_r;
  assign sync.fall = s3_r & ~s2_r;
  assign sync.rise = ~s3_r & s2_r;
endmodule

/* dmct_top.sv */
`timescale 1ns/100ps
module dmct_top
  import dmct_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic count_input_pin_zero,
  input wire logic count_input_pin_one,
  input wire logic external_gate_input_zero,
  input wire logic external_gate_input_one,
  input wire logic ext_clk_in,
  input wire logic timer_zero_vector_ack,
  input wire logic timer_one_vector_ack,
  output logic timer_zero_irq,
  output logic timer_one_irq,
  output logic timer_one_overflow_pulse
);
  logic timer_zero_overflow_flag_r;
  logic timer_one_overflow_flag_r;
  logic timer_zero_run_bit_r;
  logic timer_one_run_bit_r;
  logic [7:0] timer_mode_register_r;
  logic [7:0] clock_control_register_r;
  logic [1:0] gate_pol_r;
  logic [1:0] irq_enable_r;
  logic [7:0] timer_zero_low_byte_r;
  logic [7:0] timer_zero_high_byte_r;
  logic [7:0] timer_one_low_byte_r;
  logic [7:0] timer_one_high_byte_r;
  logic [5:0] presc_cnt_r;
  logic [DATA_W-1:0] rd_data_r;
  logic irq0_r;
  logic irq1_r;
  logic ovf_pulse_r;
  logic [DATA_W-1:0] rd_mux;
  logic [5:0] presc_div;
  logic presc_tick;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;
  logic wr_clk;
  logic wr_gpol;
  logic wr_ien;
  dmct_mode_t mode0;
  dmct_mode_t mode1;
  logic split;
  logic gate_ok0;
  logic gate_ok1;
  logic tick0;
  logic tick1;
  logic inc0;
  logic inc0h;
  logic inc1;
  logic t1_run;
  logic [16:0] step0;
  logic [16:0] step1;
  logic ovf0;
  logic ovf0h;
  logic ovf1;
  logic set_tf0;
  logic set_tf1;

  dmct_pin_if pin_bus ();

  dmct_pin_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pins({ext_clk_in, external_gate_input_one, external_gate_input_zero,
           count_input_pin_one, count_input_pin_zero}),
    .sync(pin_bus.src)
  );

  // one count step; returns {carry, high, low}
  function automatic logic [16:0] dmct_step(input dmct_mode_t m, input logic [7:0] tl, input logic [7:0] th);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = {1'b0, th, tl[4:0]} + 14'h0001;
    c16 = {1'b0, th, tl} + 17'h00001;
    c8 = {1'b0, tl} + 9'h001;
    unique case (m)
      DMCT_MODE13: dmct_step = {c13[13], c13[12:5], tl[7:5], c13[4:0]};
      DMCT_MODE16: dmct_step = c16;
      DMCT_RELOAD8: dmct_step = {c8[8], th, (c8[8] ? th : c8[7:0])};
      DMCT_SPLIT8: dmct_step = {c8[8], th, c8[7:0]};
    endcase
  endfunction

  assign wr_ctrl = dmct_hit(wr_en, addr, ADDR_CTRL);
  assign wr_mode = dmct_hit(wr_en, addr, ADDR_MODE);
  assign wr_tl0 = dmct_hit(wr_en, addr, ADDR_TL0);
  assign wr_th0 = dmct_hit(wr_en, addr, ADDR_TH0);
  assign wr_tl1 = dmct_hit(wr_en, addr, ADDR_TL1);
  assign wr_th1 = dmct_hit(wr_en, addr, ADDR_TH1);
  assign wr_clk = dmct_hit(wr_en, addr, ADDR_CLK);
  assign wr_gpol = dmct_hit(wr_en, addr, ADDR_GPOL);
  assign wr_ien = dmct_hit(wr_en, addr, ADDR_IEN);

  assign mode0 = dmct_mode_t'(timer_mode_register_r[M0_LSB+1:M0_LSB]);
  assign mode1 = dmct_mode_t'(timer_mode_register_r[M1_LSB+1:M1_LSB]);
  assign split = (mode0 == DMCT_SPLIT8);

  // shared prescaler
  always_comb begin
    unique case (clock_control_register_r[SCA_LSB+1:SCA_LSB])
      2'h0: presc_div = DIV_SYS12;
      2'h1: presc_div = DIV_SYS4;
      2'h2: presc_div = DIV_SYS48;
      2'h3: presc_div = DIV_EXT8;
    endcase
  end

  assign presc_tick = (clock_control_register_r[SCA_LSB+1:SCA_LSB] == SCA_EXT)
    ? (pin_bus.rise[PIN_EXTCLK] && (presc_cnt_r == presc_div - 6'h01))
    : (presc_cnt_r == presc_div - 6'h01);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      presc_cnt_r <= 6'h00;
    end else if (wr_clk) begin
      presc_cnt_r <= 6'h00;
    end else if (presc_tick) begin
      presc_cnt_r <= 6'h00;
    end else if (clock_control_register_r[SCA_LSB+1:SCA_LSB] != SCA_EXT || pin_bus.rise[PIN_EXTCLK]) begin
      presc_cnt_r <= presc_cnt_r + 6'h01;
    end
  end

  // gating and clock selection
  assign gate_ok0 = !timer_mode_register_r[GATE_ENABLE_BIT_BIT] ||
    (gate_pol_r[POL0_BIT] ? pin_bus.level[PIN_GATE_ENABLE_BIT] : !pin_bus.level[PIN_GATE_ENABLE_BIT]);
  assign gate_ok1 = !timer_mode_register_r[GATE1_BIT] ||
    (gate_pol_r[POL1_BIT] ? pin_bus.level[PIN_GATE1] : !pin_bus.level[PIN_GATE1]);
  assign tick0 = clock_control_register_r[T0M_BIT] || presc_tick;
  assign tick1 = clock_control_register_r[T1M_BIT] || presc_tick;
  assign inc0 = timer_zero_run_bit_r && gate_ok0 &&
    (timer_mode_register_r[CT0_BIT] ? pin_bus.fall[PIN_CNT0] : tick0);
  assign inc0h = split && timer_one_run_bit_r && tick0;
  assign t1_run = split ? (mode1 != DMCT_SPLIT8) :
    (timer_one_run_bit_r && gate_ok1 && (mode1 != DMCT_SPLIT8));
  assign inc1 = t1_run && ((timer_mode_register_r[CT1_BIT] && !split) ? pin_bus.fall[PIN_CNT1] : tick1);

  assign step0 = dmct_step(mode0, timer_zero_low_byte_r, timer_zero_high_byte_r);
  assign step1 = dmct_step(mode1, timer_one_low_byte_r, timer_one_high_byte_r);
  assign ovf0 = inc0 && step0[16];
  assign ovf0h = inc0h && (timer_zero_high_byte_r == BYTE_MAX);
  assign ovf1 = inc1 && step1[16];
  assign set_tf0 = ovf0;
  assign set_tf1 = split ? ovf0h : ovf1;

  // timer zero count; a software write wins over a count step
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_zero_low_byte_r <= RST_BYTE;
    end else if (wr_tl0) begin
      timer_zero_low_byte_r <= wr_data;
    end else if (inc0) begin
      timer_zero_low_byte_r <= step0[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_zero_high_byte_r <= RST_BYTE;
    end else if (wr_th0) begin
      timer_zero_high_byte_r <= wr_data;
    end else if (split) begin
      if (inc0h) begin
        timer_zero_high_byte_r <= timer_zero_high_byte_r + 8'h01;
      end
    end else if (inc0) begin
      timer_zero_high_byte_r <= step0[15:8];
    end
  end

  // timer one count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_one_low_byte_r <= RST_BYTE;
      timer_one_high_byte_r <= RST_BYTE;
    end else begin
      if (wr_tl1) begin
        timer_one_low_byte_r <= wr_data;
      end else if (inc1) begin
        timer_one_low_byte_r <= step1[7:0];
      end
      if (wr_th1) begin
        timer_one_high_byte_r <= wr_data;
      end else if (inc1) begin
        timer_one_high_byte_r <= step1[15:8];
      end
    end
  end

  // control bits; hardware set wins over write and acknowledge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_zero_overflow_flag_r <= 1'b0;
      timer_one_overflow_flag_r <= 1'b0;
      timer_zero_run_bit_r <= 1'b0;
      timer_one_run_bit_r <= 1'b0;
    end else begin
      if (set_tf0) begin
        timer_zero_overflow_flag_r <= 1'b1;
      end else if (wr_ctrl) begin
        timer_zero_overflow_flag_r <= wr_data[TF0_BIT];
      end else if (timer_zero_vector_ack) begin
        timer_zero_overflow_flag_r <= 1'b0;
      end
      if (set_tf1) begin
        timer_one_overflow_flag_r <= 1'b1;
      end else if (wr_ctrl) begin
        timer_one_overflow_flag_r <= wr_data[TF1_BIT];
      end else if (timer_one_vector_ack) begin
        timer_one_overflow_flag_r <= 1'b0;
      end
      if (wr_ctrl) begin
        timer_zero_run_bit_r <= wr_data[TR0_BIT];
        timer_one_run_bit_r <= wr_data[TR1_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      timer_mode_register_r <= RST_BYTE;
      clock_control_register_r <= RST_BYTE;
      gate_pol_r <= 2'h0;
      irq_enable_r <= 2'h0;
    end else begin
      if (wr_mode) begin
        timer_mode_register_r <= wr_data;
      end
      if (wr_clk) begin
        clock_control_register_r <= {4'h0, wr_data[T1M_BIT:SCA_LSB]};
      end
      if (wr_gpol) begin
        gate_pol_r <= wr_data[POL1_BIT:POL0_BIT];
      end
      if (wr_ien) begin
        irq_enable_r <= wr_data[IEN1_BIT:IEN0_BIT];
      end
    end
  end

  // outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
      ovf_pulse_r <= 1'b0;
    end else begin
      irq0_r <= timer_zero_overflow_flag_r && irq_enable_r[IEN0_BIT];
      irq1_r <= timer_one_overflow_flag_r && irq_enable_r[IEN1_BIT];
      ovf_pulse_r <= ovf1;
    end
  end

  always_comb begin
    unique case (addr)
      ADDR_CTRL: rd_mux = {timer_one_overflow_flag_r, timer_one_run_bit_r,
                           timer_zero_overflow_flag_r, timer_zero_run_bit_r, 4'h0};
      ADDR_MODE: rd_mux = timer_mode_register_r;
      ADDR_TL0: rd_mux = timer_zero_low_byte_r;
      ADDR_TH0: rd_mux = timer_zero_high_byte_r;
      ADDR_TL1: rd_mux = timer_one_low_byte_r;
      ADDR_TH1: rd_mux = timer_one_high_byte_r;
      ADDR_CLK: rd_mux = clock_control_register_r;
      ADDR_GPOL: rd_mux = {6'h00, gate_pol_r};
      ADDR_IEN: rd_mux = {6'h00, irq_enable_r};
      default: rd_mux = RST_BYTE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data_r <= RST_BYTE;
    end else begin
      rd_data_r <= rd_en ? rd_mux : RST_BYTE;
    end
  end

  assign rd_data = rd_data_r;
  assign timer_zero_irq = irq0_r;
  assign timer_one_irq = irq1_r;
  assign timer_one_overflow_pulse = ovf_pulse_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_wrap13;
    mode0 == DMCT_MODE13 && inc0 && {timer_zero_high_byte_r, timer_zero_low_byte_r[4:0]} == MAX13
      && !wr_tl0 && !wr_th0;
  endsequence
  sequence s_wrap16;
    mode0 == DMCT_MODE16 && inc0 && {timer_zero_high_byte_r, timer_zero_low_byte_r} == MAX16
      && !wr_tl0 && !wr_th0;
  endsequence
  sequence s_reload;
    mode0 == DMCT_RELOAD8 && inc0 && timer_zero_low_byte_r == BYTE_MAX && !wr_tl0 && !wr_th0;
  endsequence

  a_wrap_thirteen: assert property (s_wrap13 |=> timer_zero_high_byte_r == 8'h00 &&
    timer_zero_low_byte_r[4:0] == 5'h00 && timer_zero_overflow_flag_r) else $error("13-bit wrap wrong");
  a_wrap_sixteen: assert property (s_wrap16 |=> {timer_zero_high_byte_r, timer_zero_low_byte_r} == 16'h0000
    && timer_zero_overflow_flag_r) else $error("16-bit wrap wrong");
  a_reload_low: assert property (s_reload |=> timer_zero_low_byte_r == $past(timer_zero_high_byte_r)
    && $stable(timer_zero_high_byte_r) && timer_zero_overflow_flag_r) else $error("reload wrong");
  a_run_off_hold: assert property (!timer_zero_run_bit_r && !split && !wr_tl0 && !wr_th0
    |=> $stable(timer_zero_low_byte_r) && $stable(timer_zero_high_byte_r)) else $error("counted while stopped");
  a_irq_enable: assert property (##1 timer_zero_irq == $past(timer_zero_overflow_flag_r &&
    irq_enable_r[IEN0_BIT])) else $error("irq not flag and enable");
  a_split_flag: assert property (split && ovf0h |=> timer_one_overflow_flag_r) else $error("split high lost flag");
  a_t1_no_flag: assert property (split && !ovf0h && !wr_ctrl && !timer_one_overflow_flag_r
    |=> !timer_one_overflow_flag_r) else $error("timer one flagged in split");
  a_t1_mode3_off: assert property (mode1 == DMCT_SPLIT8 && !wr_tl1 && !wr_th1
    |=> $stable(timer_one_low_byte_r) && $stable(timer_one_high_byte_r)) else $error("timer one ran in mode 3");
  a_ovf_pulse_out: assert property (##1 timer_one_overflow_pulse == $past(ovf1))
    else $error("overflow pulse wrong");
  a_ack_clears: assert property (timer_zero_vector_ack && !set_tf0 && !wr_ctrl
    |=> !timer_zero_overflow_flag_r) else $error("ack did not clear");
  a_pin_edge_inc: assert property (mode0 == DMCT_MODE16 && timer_mode_register_r[CT0_BIT] && inc0
    && !wr_tl0 && !wr_th0
    |=> {timer_zero_high_byte_r, timer_zero_low_byte_r} ==
        $past({timer_zero_high_byte_r, timer_zero_low_byte_r}) + 16'h0001) else $error("pin edge not counted");

  // split mode: the borrowed high byte steps once per tick, timer one keeps its own clock
  a_split_high_inc: assert property (split && inc0h && !wr_th0
    |=> timer_zero_high_byte_r == $past(timer_zero_high_byte_r) + 8'h01) else $error("split high did not step");
  a_t1_split_runs: assert property (split && mode1 == DMCT_MODE16 && clock_control_register_r[T1M_BIT]
    && !wr_tl1 && !wr_th1 |=> timer_one_low_byte_r != $past(timer_one_low_byte_r))
    else $error("timer one idle in split");

  // software writes and the untouched top bits of the thirteen-bit low byte
  a_low_write_wins: assert property (wr_tl0 |=> timer_zero_low_byte_r == $past(wr_data))
    else $error("low byte write lost");
  a_mode13_top_kept: assert property (mode0 == DMCT_MODE13 && !wr_tl0
    |=> timer_zero_low_byte_r[7:5] == $past(timer_zero_low_byte_r[7:5])) else $error("low top bits changed");
endmodule

/* dmct_tb.sv */
`timescale 1ns/100ps
module testbench;
  import dmct_pkg::*;
  logic mclk;
  logic sys_rst;
  logic wr_en;
  logic rd_en;
  logic pin0;
  logic pin1;
  logic gate_enable_bit;
  logic gate1;
  logic ext_clk;
  logic ack0;
  logic ack1;
  logic [3:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] d;
  logic irq0;
  logic irq1;
  logic ovp;
  int miscompares;
  int cmp_count;
  int divs [4] = '{12, 4, 48, 32};

  dmct_top i_dut (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .count_input_pin_zero(pin0),
    .count_input_pin_one(pin1),
    .external_gate_input_zero(gate_enable_bit),
    .external_gate_input_one(gate1),
    .ext_clk_in(ext_clk),
    .timer_zero_vector_ack(ack0),
    .timer_one_vector_ack(ack1),
    .timer_zero_irq(irq0),
    .timer_one_irq(irq1),
    .timer_one_overflow_pulse(ovp)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // free-running external clock, four system cycles per period
  initial begin
    ext_clk = 1'b0;
    forever #200 ext_clk = ~ext_clk;
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    d = rd_data;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkr(input string n, input int lo, input int hi, input logic [7:0] g);
    cmp_count++;
    if ($isunknown(g) || g < lo || g > hi) begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %h", n, lo, hi, g);
    end
  endtask

  task automatic wait_for(input int w, input int lim);
    logic s;
    for (int k = 0; k < lim; k++) begin
      @(posedge mclk);
      s = (w == 0) ? irq0 : ((w == 1) ? irq1 : ovp);
      if (s === 1'b1)
        return;
    end
    miscompares++;
    $display("[ERR] wait %0d expected 1 seen timeout", w);
    final_report();
  endtask

  task automatic ack(input int w);
    @(posedge mclk);
    if (w == 0)
      ack0 <= 1'b1;
    else
      ack1 <= 1'b1;
    @(posedge mclk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
  endtask

  // load zero, run for n cycles, stop, read back the low byte
  task automatic run_for(input int n);
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    idle(n);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_TL0);
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    $display("[ERR] run expected end seen timeout");
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 8'h00;
    pin0 = 1'b1;
    pin1 = 1'b1;
    gate_enable_bit = 1'b0;
    gate1 = 1'b0;
    ack0 = 1'b0;
    ack1 = 1'b0;
    idle(2);
    sys_rst <= 1'b0;
    idle(3);
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0]);
      chk8("reset value", 8'h00, d);
    end
    rd(4'hf);
    chk8("unmapped", 8'h00, d);
    wr(ADDR_CLK, 8'hff);
    rd(ADDR_CLK);
    chk8("clk upper bits", 8'h0f, d);
    // thirteen-bit wrap
    wr(ADDR_CLK, 8'h04);
    wr(ADDR_IEN, 8'h01);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_TL0, 8'h1e);
    wr(ADDR_TH0, 8'hff);
    wr(ADDR_CTRL, 8'h10);
    wait_for(0, 20);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_TH0);
    chk8("high0 wrap13", 8'h00, d);
    rd(ADDR_TL0);
    chkr("low0 wrap13", 0, 6, {3'h0, d[4:0]});
    rd(ADDR_CTRL);
    chk8("ctrl flag0", 8'h20, d);
    wr(ADDR_IEN, 8'h00);
    idle(2);
    chk8("irq0 masked", 8'h00, {7'h0, irq0});
    wr(ADDR_IEN, 8'h01);
    idle(2);
    chk8("irq0 enabled", 8'h01, {7'h0, irq0});
    ack(0);
    idle(2);
    rd(ADDR_CTRL);
    chk8("ctrl after ack0", 8'h00, d);
    chk8("irq0 after ack", 8'h00, {7'h0, irq0});
    // sixteen-bit: 0x1ffe passes 0x2000 without a flag
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_TL0, 8'hfe);
    wr(ADDR_TH0, 8'h1f);
    wr(ADDR_CTRL, 8'h10);
    idle(8);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_TH0);
    chk8("high0 mode16", 8'h20, d);
    rd(ADDR_CTRL);
    chk8("no flag mode16", 8'h00, d);
    wr(ADDR_TL0, 8'hfe);
    wr(ADDR_TH0, 8'hff);
    wr(ADDR_CTRL, 8'h10);
    wait_for(0, 20);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_TH0);
    chk8("high0 wrap16", 8'h00, d);
    // auto-reload
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_TL0, 8'hfe);
    wr(ADDR_TH0, 8'ha0);
    wr(ADDR_CTRL, 8'h10);
    wait_for(0, 20);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_TH0);
    chk8("reload kept", 8'ha0, d);
    rd(ADDR_TL0);
    chkr("low0 reloaded", 160, 172, d);
    // falling pin edges
    wr(ADDR_MODE, 8'h05);
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    for (int k = 0; k < 6; k++) begin
      if (k == 5)
        wr(ADDR_CTRL, 8'h00);
      pin0 <= 1'b0;
      idle(4);
      pin0 <= 1'b1;
      idle(4);
    end
    rd(ADDR_TL0);
    chk8("pin count", 8'h05, d);
    // gating and polarity
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_GPOL, 8'h01);
    run_for(20);
    chk8("gate closed", 8'h00, d);
    gate_enable_bit <= 1'b1;
    run_for(20);
    chkr("gate open", 18, 26, d);
    wr(ADDR_GPOL, 8'h00);
    run_for(20);
    chk8("gate inverted", 8'h00, d);
    // prescaler settings
    wr(ADDR_MODE, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CLK, k[7:0]);
      run_for(10 * divs[k]);
      chkr("prescaled count", 9, 11, d);
    end
    // split mode
    wr(ADDR_CLK, 8'h0c);
    wr(ADDR_IEN, 8'h03);
    wr(ADDR_TL1, 8'hff);
    wr(ADDR_TH1, 8'hff);
    wr(ADDR_TH0, 8'h00);
    // counter select of timer one is set and must be ignored while split
    wr(ADDR_MODE, 8'h53);
    wait_for(2, 10);
    rd(ADDR_CTRL);
    chk8("timer one no flag", 8'h00, d);
    wr(ADDR_TH0, 8'hf0);
    wr(ADDR_CTRL, 8'h40);
    wait_for(1, 40);
    rd(ADDR_CTRL);
    chk8("split high flag", 8'hc0, d);
    ack(1);
    idle(2);
    rd(ADDR_CTRL);
    chk8("ctrl after ack1", 8'h40, d);
    chk8("irq1 after ack", 8'h00, {7'h0, irq1});
    // timer one halted in its own mode 3
    wr(ADDR_MODE, 8'h32);
    wr(ADDR_TL1, 8'h11);
    idle(10);
    rd(ADDR_TL1);
    chk8("timer one halted", 8'h11, d);
    // timer one counts its own pin, gated by its own input
    wr(ADDR_GPOL, 8'h02);
    wr(ADDR_MODE, 8'hd0);
    wr(ADDR_TL1, 8'h00);
    gate1 <= 1'b1;
    wr(ADDR_CTRL, 8'h40);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) begin
        gate1 <= 1'b0;
        idle(2);
      end
      pin1 <= 1'b0;
      idle(4);
      pin1 <= 1'b1;
      idle(4);
    end
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_TL1);
    chk8("pin one gated count", 8'h03, d);
    final_report();
  end
endmodule
